// file: hdl/pdw_defs.svh
// Constants of the power-down and wake sequencer
`ifndef PDW_DEFS_SVH
`define PDW_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets (haddr[7:0])
// ------------------------------------------------------------
`define PDW_ADDR_CLK_SEL   8'h00
`define PDW_ADDR_STOP_CTL  8'h04
`define PDW_ADDR_STAB_CTL  8'h08
`define PDW_ADDR_STAB_CNT  8'h0C
`define PDW_ADDR_STATUS    8'h10
`define PDW_ADDR_WAKE_EN   8'h14

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define PDW_CLK_DIV_LSB    3
`define PDW_CLK_DIV_MSB    4
`define PDW_CLK_SEL_RST    8'h00
`define PDW_STOP_CTL_RST   8'h00
`define PDW_STOP_KEY       8'hA5
`define PDW_STAB_SEL_RST   2'h0
`define PDW_STAB_CLR_BIT   2
`define PDW_WAKE_EN_RST    4'h0
`define PDW_STAB_DONE_BIT  4
`define PDW_RESET_VECTOR   16'h0100

// ------------------------------------------------------------
// Opcodes and bus codes
// ------------------------------------------------------------
`define PDW_OP_STOP        8'h7F
`define PDW_OP_IDLE        8'h6F
`define PDW_HSIZE_WORD     3'h2

`endif

// file: hdl/pdw_pkg.sv
// Types of the power-down and wake sequencer
package pdw_pkg;

   typedef enum logic [2:0] {
      PDW_RUN,
      PDW_STOP,
      PDW_IDLE,
      PDW_STAB,
      PDW_RSTH
   } pdw_state_t;

   typedef struct packed {
      pdw_state_t  st;
      logic        rst_cause;
      logic [7:0]  clk_sel;
      logic [7:0]  stop_ctl;
      logic [1:0]  stab_sel;
      logic [3:0]  wake_en;
      logic [7:0]  stab_cnt;
      logic        ph_wr;
      logic        ph_rd;
      logic [7:0]  ph_addr;
      logic        hready;
      logic [31:0] hrdata;
      logic        osc_en;
      logic        cpu_clk_en;
      logic        periph_en;
      logic        dir_hold;
      logic        cpu_rst;
      logic        fetch;
      logic [15:0] fetch_addr;
      logic        irq_svc;
   } pdw_regs_t;

endpackage : pdw_pkg

// file: hdl/pdw_power_ctrl.sv
// Power-down and wake sequencer: stop and idle control over AHB-Lite
//
// Behaviour
// - Stop opcode halts oscillator, CPU, peripherals
// - Reset release leaves stop, restores controls
// - Reset clears divider select to slowest
// - Reset wake fetches at reset vector
// - CPU gated until stabilization bit four
// - Four enabled external lines or the watch timer on sub oscillator wake stop
// - Interrupt stop wake clears only stop control
// - Interrupt stop wake keeps divider select
// - Waking interrupt serviced, then resume
// - Watch timer on sub oscillator wakes
// - Idle gates CPU clock, peripherals run
// - Pins keep direction during idle
// - Reset ends idle, restores defaults
// - Masked interrupts: only reset ends idle
// - Enabled interrupt ends idle, divider kept
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "pdw_defs.svh"
module pdw_power_ctrl #(
   parameter int unsigned STAB_DIV_SLOW = 4096,
   parameter int unsigned STAB_DIV_MID  = 1024,
   parameter int unsigned STAB_DIV_FAST = 128
) (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic [31:0]      hrdata_o,
   output logic             hresp_o,
   input  wire logic        cpu_exec_i,
   input  wire logic [7:0]  cpu_opcode_i,
   input  wire logic        irq_pending_i,
   input  wire logic        irq_global_en_i,
   input  wire logic [3:0]  external_wake_lines_i,
   input  wire logic        wt_irq_i,
   input  wire logic        wt_sub_osc_i,
   input  wire logic        rst_pin_n_i,
   output logic             osc_en_o,
   output logic             cpu_clk_en_o,
   output logic             periph_clk_en_o,
   output logic             port_dir_hold_o,
   output logic             cpu_rst_o,
   output logic             fetch_start_o,
   output logic [15:0]      fetch_addr_o,
   output logic             irq_service_o,
   output logic [1:0]       clk_div_sel_o
);
   pdw_pkg::pdw_regs_t q;
   pdw_pkg::pdw_regs_t d;
   logic [3:0]         ext_sync;
   logic               rst_n_sync;
   logic               stab_tick;
   logic               stop_wake;
   logic               idle_wake;
   logic               entry_stop;
   logic               entry_idle;
   logic [7:0]         rd_val;

   // ------------------------------------------------------------
   // Pin synchronisers and stabilization prescaler
   // ------------------------------------------------------------
   pdw_sync #(
      .WIDTH   (4),
      .RST_VAL (1'b0)
   ) u_ext_sync (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .async_i    (external_wake_lines_i),
      .sync_o     (ext_sync)
   );

   pdw_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   ) u_rst_sync (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .async_i    (rst_pin_n_i),
      .sync_o     (rst_n_sync)
   );

   pdw_prescaler #(
      .DIV_SLOW (STAB_DIV_SLOW),
      .DIV_MID  (STAB_DIV_MID),
      .DIV_FAST (STAB_DIV_FAST)
   ) u_stab_presc (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .clr_i      (q.st != pdw_pkg::PDW_STAB),
      .sel_i      (q.stab_sel),
      .tick_o     (stab_tick)
   );

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      d         = q;
      d.fetch   = 1'b0;
      d.irq_svc = 1'b0;
      d.hready  = 1'b1;
      stop_wake = (|(ext_sync & q.wake_en)) | (wt_irq_i & wt_sub_osc_i);
      idle_wake = irq_pending_i & irq_global_en_i;
      entry_stop = cpu_exec_i && (cpu_opcode_i == `PDW_OP_STOP) &&
                   (q.stop_ctl == `PDW_STOP_KEY);
      entry_idle = cpu_exec_i && (cpu_opcode_i == `PDW_OP_IDLE);

      // Data phase of a bus write
      if (q.ph_wr) begin
         case (q.ph_addr)
            `PDW_ADDR_CLK_SEL: begin
               d.clk_sel = hwdata_i[7:0];
            end
            `PDW_ADDR_STOP_CTL: begin
               d.stop_ctl = hwdata_i[7:0];
            end
            `PDW_ADDR_STAB_CTL: begin
               d.stab_sel = hwdata_i[1:0];
               if (hwdata_i[`PDW_STAB_CLR_BIT]) begin
                  d.stab_cnt = '0;
               end
            end
            `PDW_ADDR_WAKE_EN: begin
               d.wake_en = hwdata_i[3:0];
            end
            default: begin
               d.wake_en = q.wake_en;
            end
         endcase
      end

      // Power sequencer
      case (q.st)
         pdw_pkg::PDW_RUN: begin
            if (entry_stop && !stop_wake) begin
               d.st = pdw_pkg::PDW_STOP;
            end else if (entry_idle && !idle_wake) begin
               d.st = pdw_pkg::PDW_IDLE;
            end
         end
         pdw_pkg::PDW_STOP: begin
            if (stop_wake) begin
               d.st        = pdw_pkg::PDW_STAB;
               d.rst_cause = 1'b0;
               d.stop_ctl  = `PDW_STOP_CTL_RST;
               d.stab_cnt  = '0;
            end
         end
         pdw_pkg::PDW_IDLE: begin
            if (idle_wake) begin
               d.st      = pdw_pkg::PDW_RUN;
               d.irq_svc = 1'b1;
            end
         end
         pdw_pkg::PDW_STAB: begin
            if (stab_tick) begin
               d.stab_cnt = q.stab_cnt + 8'h01;
               if (d.stab_cnt[`PDW_STAB_DONE_BIT]) begin
                  d.st = pdw_pkg::PDW_RUN;
                  if (q.rst_cause) begin
                     d.fetch      = 1'b1;
                     d.fetch_addr = `PDW_RESET_VECTOR;
                  end else begin
                     d.irq_svc = 1'b1;
                  end
               end
            end
         end
         pdw_pkg::PDW_RSTH: begin
            if (rst_n_sync) begin
               d.st       = pdw_pkg::PDW_STAB;
               d.stab_cnt = '0;
            end
         end
         default: begin
            d.st = pdw_pkg::PDW_RSTH;
         end
      endcase

      // Reset pin low: controls to defaults, data kept outside
      if (!rst_n_sync) begin
         d.st        = pdw_pkg::PDW_RSTH;
         d.rst_cause = 1'b1;
         d.clk_sel   = `PDW_CLK_SEL_RST;
         d.stop_ctl  = `PDW_STOP_CTL_RST;
         d.stab_sel  = `PDW_STAB_SEL_RST;
         d.wake_en   = `PDW_WAKE_EN_RST;
         d.stab_cnt  = '0;
      end

      // Clock and pin control follow the next state
      d.osc_en     = (d.st != pdw_pkg::PDW_STOP);
      d.cpu_clk_en = (d.st == pdw_pkg::PDW_RUN);
      d.periph_en  = (d.st == pdw_pkg::PDW_RUN) || (d.st == pdw_pkg::PDW_IDLE);
      d.dir_hold   = (d.st == pdw_pkg::PDW_IDLE) || (d.st == pdw_pkg::PDW_STOP);
      d.cpu_rst    = (d.st == pdw_pkg::PDW_RSTH) ||
                     ((d.st == pdw_pkg::PDW_STAB) && d.rst_cause);

      // Address phase capture; read data taken after any pending write
      d.ph_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i &&
                (hsize_i == `PDW_HSIZE_WORD);
      d.ph_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
      if (hready_i) begin
         d.ph_addr = haddr_i[7:0];
      end
      case (haddr_i[7:0])
         `PDW_ADDR_CLK_SEL: begin
            rd_val = d.clk_sel;
         end
         `PDW_ADDR_STOP_CTL: begin
            rd_val = d.stop_ctl;
         end
         `PDW_ADDR_STAB_CTL: begin
            rd_val = {6'h00, d.stab_sel};
         end
         `PDW_ADDR_STAB_CNT: begin
            rd_val = d.stab_cnt;
         end
         `PDW_ADDR_STATUS: begin
            rd_val = {4'h0, d.rst_cause, (d.st == pdw_pkg::PDW_STAB),
                      (d.st == pdw_pkg::PDW_IDLE), (d.st == pdw_pkg::PDW_STOP)};
         end
         `PDW_ADDR_WAKE_EN: begin
            rd_val = {4'h0, d.wake_en};
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
      if (d.ph_rd) begin
         d.hrdata = {24'h000000, rd_val};
      end else if (hready_i) begin
         d.hrdata = 32'h00000000;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q            <= '0;
         q.st         <= pdw_pkg::PDW_RSTH;
         q.rst_cause  <= 1'b1;
         q.clk_sel    <= `PDW_CLK_SEL_RST;
         q.stop_ctl   <= `PDW_STOP_CTL_RST;
         q.stab_sel   <= `PDW_STAB_SEL_RST;
         q.wake_en    <= `PDW_WAKE_EN_RST;
         q.hready     <= 1'b1;
         q.osc_en     <= 1'b1;
         q.cpu_rst    <= 1'b1;
         q.fetch_addr <= `PDW_RESET_VECTOR;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign hreadyout_o     = q.hready;
   assign hrdata_o        = q.hrdata;
   assign hresp_o         = 1'b0;
   assign osc_en_o        = q.osc_en;
   assign cpu_clk_en_o    = q.cpu_clk_en;
   assign periph_clk_en_o = q.periph_en;
   assign port_dir_hold_o = q.dir_hold;
   assign cpu_rst_o       = q.cpu_rst;
   assign fetch_start_o   = q.fetch;
   assign fetch_addr_o    = q.fetch_addr;
   assign irq_service_o   = q.irq_svc;
   assign clk_div_sel_o   = q.clk_sel[`PDW_CLK_DIV_MSB:`PDW_CLK_DIV_LSB];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   stop_halts_all_a: assert property (
      (q.st == pdw_pkg::PDW_STOP) |-> (!osc_en_o && !cpu_clk_en_o && !periph_clk_en_o))
      else $error("stop state with a clock running");

   reset_exit_stop_a: assert property (
      (q.st == pdw_pkg::PDW_STOP) && !rst_n_sync |=> (q.st == pdw_pkg::PDW_RSTH))
      else $error("reset did not lead from stop to reset hold");

   reset_release_a: assert property (
      (q.st == pdw_pkg::PDW_RSTH) && rst_n_sync |=> (q.st == pdw_pkg::PDW_STAB))
      else $error("reset release did not start stabilization");

   reset_div_slow_a: assert property (
      !rst_n_sync |=> (clk_div_sel_o == 2'h0) && (q.stab_sel == 2'h0))
      else $error("divider select not cleared by reset");

   vector_fetch_a: assert property (
      fetch_start_o |-> (fetch_addr_o == `PDW_RESET_VECTOR) && cpu_clk_en_o
      && $past(q.st == pdw_pkg::PDW_STAB) && $past(q.rst_cause))
      else $error("fetch start without reset wake at vector");

   stab_gates_cpu_a: assert property (
      (q.st == pdw_pkg::PDW_STAB) |-> osc_en_o && !cpu_clk_en_o &&
      !q.stab_cnt[`PDW_STAB_DONE_BIT])
      else $error("cpu clock open during stabilization");

   ext_wake_stop_a: assert property (
      (q.st == pdw_pkg::PDW_STOP) && rst_n_sync && (|(ext_sync & q.wake_en))
      |=> (q.st == pdw_pkg::PDW_STAB) && !q.rst_cause)
      else $error("enabled external line did not wake stop");

   irq_wake_keeps_a: assert property (
      (q.st == pdw_pkg::PDW_STOP) && rst_n_sync && stop_wake && !q.ph_wr
      |=> $stable(q.clk_sel) && $stable(q.wake_en) && (q.stop_ctl == `PDW_STOP_CTL_RST))
      else $error("interrupt stop wake changed controls");

   div_kept_wake_a: assert property (
      $fell(q.st == pdw_pkg::PDW_STOP) && !q.rst_cause && !$past(q.ph_wr)
      |-> $stable(clk_div_sel_o))
      else $error("divider select changed on interrupt wake");

   wt_wake_a: assert property (
      (q.st == pdw_pkg::PDW_STOP) && rst_n_sync && wt_irq_i && wt_sub_osc_i
      |=> (q.st == pdw_pkg::PDW_STAB))
      else $error("watch timer interrupt did not wake stop");

   idle_clocks_a: assert property (
      (q.st == pdw_pkg::PDW_IDLE) |-> periph_clk_en_o && !cpu_clk_en_o && port_dir_hold_o)
      else $error("idle clocks or pin hold wrong");

   idle_masked_a: assert property (
      (q.st == pdw_pkg::PDW_IDLE) && rst_n_sync && !irq_global_en_i
      |=> (q.st == pdw_pkg::PDW_IDLE))
      else $error("idle left while interrupts masked");

   idle_irq_exit_a: assert property (
      (q.st == pdw_pkg::PDW_IDLE) && rst_n_sync && idle_wake
      |=> (q.st == pdw_pkg::PDW_RUN) && irq_service_o ##1 !irq_service_o)
      else $error("enabled interrupt did not end idle");

   wake_priority_a: assert property (
      (q.st == pdw_pkg::PDW_RUN) && rst_n_sync && entry_idle && idle_wake
      |=> (q.st == pdw_pkg::PDW_RUN))
      else $error("idle entered despite pending wake");
endmodule : pdw_power_ctrl

// file: hdl/pdw_prescaler.sv
// Selectable clock prescaler feeding the stabilization counter
`timescale 1ns/1ps
module pdw_prescaler #(
   parameter int unsigned DIV_SLOW = 4096,
   parameter int unsigned DIV_MID  = 1024,
   parameter int unsigned DIV_FAST = 128
) (
   input  wire logic       core_clk_i,
   input  wire logic       srst_i,
   input  wire logic       clr_i,
   input  wire logic [1:0] sel_i,
   output logic            tick_o
);
   localparam int unsigned CW = $clog2(DIV_SLOW);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } ps_t;

   ps_t           q;
   ps_t           d;
   logic [CW-1:0] last;

   always_comb begin
      case (sel_i)
         2'h0: begin
            last = CW'(DIV_SLOW - 1);
         end
         2'h1: begin
            last = CW'(DIV_MID - 1);
         end
         default: begin
            last = CW'(DIV_FAST - 1);
         end
      endcase
      d      = q;
      d.tick = 1'b0;
      if (clr_i) begin
         d.cnt = '0;
      end else if (q.cnt >= last) begin
         d.cnt  = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick_o = q.tick;
endmodule : pdw_prescaler

// file: hdl/pdw_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pdw_sync #(
   parameter int unsigned WIDTH    = 1,
   parameter logic        RST_VAL  = 1'b0
) (
   input  wire logic             core_clk_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_t;

   sync_t q;
   sync_t d;

   always_comb begin
      d    = q;
      d.s1 = async_i;
      d.s2 = q.s1;
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q <= {(2 * WIDTH){RST_VAL}};
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.s2;
endmodule : pdw_sync

// file: test/pdw_cpu_model.sv
// CPU core, interrupt sources and reset pin around the power-down sequencer
`timescale 1ns/1ps
module pdw_cpu_model (
   input  wire logic  core_clk_i,
   input  wire logic  irq_service_i,
   output logic       cpu_exec_o,
   output logic [7:0] cpu_opcode_o,
   output logic       irq_pending_o,
   output logic       irq_global_en_o,
   output logic [3:0] wake_lines_o,
   output logic       wt_irq_o,
   output logic       wt_sub_osc_o,
   output logic       rst_pin_n_o
);
   initial begin
      cpu_exec_o      = 1'b0;
      cpu_opcode_o    = 8'h00;
      irq_pending_o   = 1'b0;
      irq_global_en_o = 1'b0;
      wake_lines_o    = 4'h0;
      wt_irq_o        = 1'b0;
      wt_sub_osc_o    = 1'b0;
      rst_pin_n_o     = 1'b1;
   end

   // Servicing the waking interrupt retires every request
   always @(posedge core_clk_i) begin
      if (irq_service_i === 1'b1) begin
         irq_pending_o <= 1'b0;
         wake_lines_o  <= 4'h0;
         wt_irq_o      <= 1'b0;
      end
   end

   // One opcode strobe; outside it the opcode bus carries a changed pattern
   task automatic exec_op(input logic [7:0] op);
      @(posedge core_clk_i);
      cpu_exec_o   <= 1'b1;
      cpu_opcode_o <= op;
      @(posedge core_clk_i);
      cpu_exec_o   <= 1'b0;
      cpu_opcode_o <= ~op;
   endtask : exec_op

   task automatic raise(input logic [3:0] ln, input logic pend, input logic en,
                        input logic wt, input logic sub);
      @(posedge core_clk_i);
      wake_lines_o    <= ln;
      irq_pending_o   <= pend;
      irq_global_en_o <= en;
      wt_irq_o        <= wt;
      wt_sub_osc_o    <= sub;
   endtask : raise

   task automatic pin_reset(input int n);
      @(posedge core_clk_i);
      rst_pin_n_o <= 1'b0;
      repeat (n) @(posedge core_clk_i);
      rst_pin_n_o <= 1'b1;
   endtask : pin_reset
endmodule : pdw_cpu_model

// file: test/test_power_down_wake_control.sv
// Self-checking bench of the power-down and wake sequencer
`timescale 1ns/1ps
`include "pdw_defs.svh"
module test_power_down_wake_control;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] rv;
      logic [31:0] wd;
      logic [31:0] ev;
   } pdw_row_t;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic        hreadyout_o, hresp_o, osc_en_o, cpu_clk_en_o, periph_clk_en_o;
   logic        port_dir_hold_o, cpu_rst_o, fetch_start_o, irq_service_o;
   logic        exec, pend, gen, wt, sub, pin_n;
   logic [7:0]  op;
   logic [3:0]  lines;
   logic [31:0] hrdata_o;
   logic [15:0] fetch_addr_o;
   logic [1:0]  clk_div_sel_o;
   int          n_errors = 0, check_count = 0;
   pdw_row_t    rows [7] = '{'{8'h00, 32'h0, 32'hFFFF_FF18, 32'h18},
      '{8'h04, 32'h0, 32'h5A, 32'h5A}, '{8'h08, 32'h0, 32'h01, 32'h01},
      '{8'h14, 32'h0, 32'h0F, 32'h0F}, '{8'h0C, 32'h10, 32'hFF, 32'h10},
      '{8'h10, 32'h08, 32'hFF, 32'h08}, '{8'h20, 32'h0, 32'hFFFF_FFFF, 32'h0}};

   always #2 core_clk = ~core_clk;

   pdw_power_ctrl #(.STAB_DIV_SLOW(8), .STAB_DIV_MID(4), .STAB_DIV_FAST(2)) uut (
      .core_clk_i(core_clk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o),
      .hresp_o(hresp_o), .cpu_exec_i(exec), .cpu_opcode_i(op), .irq_pending_i(pend),
      .irq_global_en_i(gen), .external_wake_lines_i(lines), .wt_irq_i(wt),
      .wt_sub_osc_i(sub), .rst_pin_n_i(pin_n), .osc_en_o(osc_en_o),
      .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
      .port_dir_hold_o(port_dir_hold_o), .cpu_rst_o(cpu_rst_o),
      .fetch_start_o(fetch_start_o), .fetch_addr_o(fetch_addr_o),
      .irq_service_o(irq_service_o), .clk_div_sel_o(clk_div_sel_o));

   pdw_cpu_model cpu (
      .core_clk_i(core_clk), .irq_service_i(irq_service_o), .cpu_exec_o(exec),
      .cpu_opcode_o(op), .irq_pending_o(pend), .irq_global_en_o(gen),
      .wake_lines_o(lines), .wt_irq_o(wt), .wt_sub_osc_o(sub), .rst_pin_n_o(pin_n));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      if (n_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask : chk

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      hsize  <= `PDW_HSIZE_WORD;
      do @(posedge core_clk); while (hreadyout_o !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout_o !== 1'b1);
      rdat = hrdata_o;
      chk("hresp", 32'h0, {31'h0, hresp_o});
   endtask : ahb

   // Waits for the fetch (sel 0) or service (sel 1) pulse, checks the delay window
   task automatic wait_pulse(input logic sel, input int lo);
      int n;
      n = 0;
      while ((sel ? irq_service_o : fetch_start_o) !== 1'b1 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      chk("wake_delay_ok", 32'h1, {31'h0, (n >= lo && n <= lo + 12)});
      if (!sel)
         chk("fetch_addr", {16'h0, `PDW_RESET_VECTOR}, {16'h0, fetch_addr_o});
      @(negedge core_clk);
      chk("cpu_clk_en_run", 32'h1, {31'h0, cpu_clk_en_o});
   endtask : wait_pulse

   task automatic enter(input logic [7:0] opc);
      cpu.exec_op(opc);
      repeat (2) @(negedge core_clk);
   endtask : enter

   initial begin
      repeat (5000) @(posedge core_clk);
      n_errors++;
      stop_test();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      @(negedge core_clk);
      chk("cpu_rst_hold", 32'h1, {31'h0, cpu_rst_o});
      chk("clk_div_rst", 32'h0, {30'h0, clk_div_sel_o});
      wait_pulse(1'b0, 128);
      foreach (rows[i]) begin
         ahb(1'b0, rows[i].a, 32'h0);
         chk("reg_reset", rows[i].rv, rdat);
         ahb(1'b1, rows[i].a, rows[i].wd);
         ahb(1'b0, rows[i].a, 32'h0);
         chk("reg_rw", rows[i].ev, rdat);
      end
      ahb(1'b1, `PDW_ADDR_STAB_CTL, 32'h2);
      ahb(1'b1, `PDW_ADDR_STOP_CTL, {24'h0, `PDW_STOP_KEY});
      enter(`PDW_OP_STOP);
      chk("stop_clocks", 32'h0, {29'h0, osc_en_o, cpu_clk_en_o, periph_clk_en_o});
      chk("stop_dir_hold", 32'h1, {31'h0, port_dir_hold_o});
      repeat (20) @(negedge core_clk);
      chk("stop_stays", 32'h0, {31'h0, osc_en_o});
      cpu.raise(4'h4, 1'b0, 1'b0, 1'b0, 1'b0);
      wait_pulse(1'b1, 32);
      chk("div_kept_stop", 32'h3, {30'h0, clk_div_sel_o});
      ahb(1'b0, `PDW_ADDR_STOP_CTL, 32'h0);
      chk("stop_ctl_cleared", 32'h0, rdat);
      ahb(1'b0, `PDW_ADDR_CLK_SEL, 32'h0);
      chk("clk_sel_kept", 32'h18, rdat);
      cpu.raise(4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      ahb(1'b1, `PDW_ADDR_STOP_CTL, {24'h0, `PDW_STOP_KEY});
      enter(`PDW_OP_STOP);
      repeat (20) @(negedge core_clk);
      chk("wt_main_osc_no_wake", 32'h0, {31'h0, osc_en_o});
      cpu.raise(4'h0, 1'b0, 1'b0, 1'b1, 1'b1);
      wait_pulse(1'b1, 32);
      cpu.raise(4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      enter(`PDW_OP_STOP);
      chk("stop_needs_key", 32'h1, {31'h0, cpu_clk_en_o});
      cpu.raise(4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
      enter(`PDW_OP_IDLE);
      chk("idle_clocks", 32'h1, {30'h0, cpu_clk_en_o, periph_clk_en_o});
      chk("idle_dir_hold", 32'h1, {31'h0, port_dir_hold_o});
      repeat (20) @(negedge core_clk);
      chk("idle_masked", 32'h0, {31'h0, cpu_clk_en_o});
      cpu.raise(4'h0, 1'b1, 1'b1, 1'b0, 1'b0);
      wait_pulse(1'b1, 0);
      chk("div_kept_idle", 32'h3, {30'h0, clk_div_sel_o});
      cpu.raise(4'h0, 1'b1, 1'b1, 1'b0, 1'b0);
      enter(`PDW_OP_IDLE);
      chk("wake_beats_entry", 32'h1, {31'h0, cpu_clk_en_o});
      cpu.raise(4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (4) @(negedge core_clk);
      enter(`PDW_OP_IDLE);
      chk("idle_again", 32'h0, {31'h0, cpu_clk_en_o});
      cpu.pin_reset(6);
      @(negedge core_clk);
      chk("idle_rst_div", 32'h0, {30'h0, clk_div_sel_o});
      chk("idle_rst_cpu", 32'h1, {31'h0, cpu_rst_o});
      wait_pulse(1'b0, 128);
      ahb(1'b0, `PDW_ADDR_CLK_SEL, 32'h0);
      chk("idle_rst_clk_sel", 32'h0, rdat);
      ahb(1'b1, `PDW_ADDR_STOP_CTL, {24'h0, `PDW_STOP_KEY});
      enter(`PDW_OP_STOP);
      chk("stop_osc_off", 32'h0, {31'h0, osc_en_o});
      cpu.pin_reset(6);
      @(negedge core_clk);
      chk("stop_rst_osc", 32'h3, {30'h0, osc_en_o, cpu_rst_o});
      wait_pulse(1'b0, 128);
      ahb(1'b0, `PDW_ADDR_STOP_CTL, 32'h0);
      chk("stop_rst_ctl", 32'h0, rdat);
      stop_test();
   end
endmodule : test_power_down_wake_control
